// >>> core/tsr_pkg.sv
// package for the thermal shutdown and restart controller
// assumes one system clock and a classic wishbone master on the register side
`default_nettype none
package tsr_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [7:0] TSR_STATUS_OFS = 8'h0C;
  localparam logic [7:0] TSR_CHGCTL_OFS = 8'h10;
  localparam logic [7:0] TSR_CTRL_OFS   = 8'h1C;

  // status register bit positions
  localparam int STAT_SHUT_BIT  = 0;
  localparam int STAT_EW_BIT    = 1;
  localparam int STAT_LIMIT_BIT = 2;
  localparam int STAT_HOT90_BIT = 3;
  localparam int STAT_WAIT_BIT  = 4;

  // control and charger control field positions
  localparam int CTRL_AUTO_BIT = 0;
  localparam int CHG_TERM_LSB  = 0;
  localparam int CHG_OFS_LSB   = 2;

  // reset values
  localparam logic       AUTO_RST     = 1'b0;
  localparam logic [1:0] TERM_SEL_RST = 2'h1;
  localparam logic [1:0] OFS_SEL_RST  = 2'h1;

  // temperature thresholds in degrees celsius
  localparam int TEMP_SHUTDOWN_C = 160;
  localparam int TEMP_CHG_REG_C  = 115;
  localparam int TEMP_EARLY_C    = 105;
  localparam int TEMP_EW_HYST_C  = 15;
  localparam int TEMP_RECOVER_C  = 90;

  // comparator input indices, one bit per threshold
  localparam int CMP_N       = 4;
  localparam int CMP_RECOVER = 0;
  localparam int CMP_EARLY   = 1;
  localparam int CMP_CHG_REG = 2;
  localparam int CMP_SHUT    = 3;

  // power-on trigger sources: key, charger supply, usb supply
  localparam int PWR_SRC_N = 3;

  // charger voltage levels in millivolts
  localparam int              LVL_W        = 13;
  localparam logic [LVL_W-1:0] TERM_BASE_MV = 13'h1004;
  localparam logic [LVL_W-1:0] TERM_STEP_MV = 13'h0064;
  localparam logic [LVL_W-1:0] OFS_BASE_MV  = 13'h0032;
  localparam logic [LVL_W-1:0] OFS_STEP_MV  = 13'h0032;

  typedef enum logic [1:0] {FSM_RUN, FSM_COOL, FSM_WAIT_TRIG} tsr_fsm_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } tsr_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tsr_wb_rsp_type;

endpackage
`default_nettype wire

// >>> core/tsr_thermal_ctl.sv
// thermal shutdown and restart controller with wishbone registers
// assumes comparator and trigger inputs are asynchronous pins and that a
// separate sequencer consumes the power-down and power-up pulses
//
// The placing of the registers and the Wishbone interface to the registers were left to the implementer.
`default_nettype none

// Summary of operation
// R01: crossing the shutdown threshold sets the high-temp shutdown flag.
// R02: crossing the shutdown threshold issues a power-down with no software.
// R03: after an overheat shutdown no restart happens until below recovery.
// R04: with auto restart clear, restart waits for a key, charger or usb edge.
// R05: with auto restart set, a power-up is issued once the die has cooled.
// R06: an automatic restart leaves every programmed register untouched.
// R07: no power-up is issued while the die is at or above recovery level.
// R08: exceeding the early-warning threshold sets the early-warning flag.
// R09: the early-warning flag clears only below threshold minus hysteresis.
// R10: exceeding the regulation threshold tells the charger to cut current.
// R11: termination and restart levels come from two 2-bit charger fields.
// R12: the restart level is an offset below the selected termination level.
// R13: termination codes 0..3 are 4.1 to 4.4 volts, reset code gives 4.2.
// R14: offset codes 0..3 are 50 to 200 millivolts, reset code gives 100.
// R15: every comparator input is synchronised before any logic uses it.
// R16: power-down and power-up requests are single-cycle pulses.
module tsr_thermal_ctl
  import tsr_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 resetn,
  // register bus
  input  wire tsr_wb_req_type       wb_req,
  output var  tsr_wb_rsp_type       wb_rsp,
  // comparator results, bit set while above its threshold
  input  wire logic [CMP_N-1:0]     temp_cmp_in,
  // normal power-on triggers
  input  wire logic                 power_key_input,
  input  wire logic                 charger_supply_input,
  input  wire logic                 usb_supply_input,
  // sequencer requests
  output logic                      power_down_req,
  output logic                      power_up_req,
  // charger controls
  output logic                      charge_current_limit,
  output logic [LVL_W-1:0]          term_level_mv,
  output logic [LVL_W-1:0]          restart_level_mv,
  // status mirrors
  output logic                      high_temp_shutdown_flag,
  output logic                      early_warning_flag
);

  // the clear point of the early warning must equal the recovery comparator
  if (TEMP_EARLY_C - TEMP_EW_HYST_C != TEMP_RECOVER_C) begin : g_hyst_chk
    $error("early warning hysteresis does not meet the recovery threshold");
  end

  typedef struct packed {
    logic [CMP_N-1:0]     cmp_s1;
    logic [CMP_N-1:0]     cmp_s2;
    logic [PWR_SRC_N-1:0] src_s1;
    logic [PWR_SRC_N-1:0] src_s2;
    logic [PWR_SRC_N-1:0] src_prev;
    tsr_fsm_type          fsm;
    logic                 shut_flag;
    logic                 ew_flag;
    logic                 limit;
    logic                 auto_rst;
    logic [1:0]           term_sel;
    logic [1:0]           ofs_sel;
    logic                 pd_req;
    logic                 pu_req;
    logic [LVL_W-1:0]     term_mv;
    logic [LVL_W-1:0]     rst_mv;
    logic                 ack;
    logic [31:0]          rdat;
  } tsr_st_type;

  // linear code to millivolt decode, shared by both charger fields
  function automatic logic [LVL_W-1:0] lvl_decode(
    input logic [LVL_W-1:0] base,
    input logic [LVL_W-1:0] step,
    input logic [1:0]       code
  );
    logic [LVL_W-1:0] code_w;
    code_w = {{(LVL_W-2){1'b0}}, code};
    return LVL_W'(base + LVL_W'(step * code_w));
  endfunction

  localparam logic [LVL_W-1:0] TERM_MV_RST =
    LVL_W'(TERM_BASE_MV + TERM_STEP_MV);
  localparam logic [LVL_W-1:0] RST_MV_RST =
    LVL_W'(TERM_MV_RST - LVL_W'(OFS_BASE_MV + OFS_STEP_MV));

  localparam tsr_st_type ST_RST = '{
    fsm:      FSM_RUN,
    auto_rst: AUTO_RST,
    term_sel: TERM_SEL_RST,
    ofs_sel:  OFS_SEL_RST,
    term_mv:  TERM_MV_RST,
    rst_mv:   RST_MV_RST,
    default:  '0
  };

  tsr_st_type st_reg;
  tsr_st_type st_next;

  // decoded views of the synchronised inputs and the bus
  logic                 hot_shut;
  logic                 hot_early;
  logic                 hot_reg;
  logic                 hot_recover;
  logic                 trig_rise;
  logic                 bus_req;
  logic                 bus_wr;
  logic [7:0]           word_adr;
  logic [LVL_W-1:0]     term_calc;

  // only second-stage flops feed logic; first stages stay private
  assign hot_shut    = st_reg.cmp_s2[CMP_SHUT];       // see R15
  assign hot_early   = st_reg.cmp_s2[CMP_EARLY];
  assign hot_reg     = st_reg.cmp_s2[CMP_CHG_REG];
  assign hot_recover = st_reg.cmp_s2[CMP_RECOVER];
  assign trig_rise   = |(st_reg.src_s2 & ~st_reg.src_prev);
  assign bus_req     = wb_req.cyc & wb_req.stb & ~st_reg.ack;
  assign bus_wr      = bus_req & wb_req.we & wb_req.sel[0];
  assign word_adr    = {wb_req.adr[7:2], 2'b00};

  // next-state logic for the whole block
  always_comb begin
    st_next = st_reg;
    term_calc = '0;

    // two-flop synchronisers and trigger edge history
    st_next.cmp_s1   = temp_cmp_in;                   // see R15
    st_next.cmp_s2   = st_reg.cmp_s1;
    st_next.src_s1   = {usb_supply_input, charger_supply_input,
                        power_key_input};
    st_next.src_s2   = st_reg.src_s1;
    st_next.src_prev = st_reg.src_s2;

    // requests are pulses by default
    st_next.pd_req = 1'b0;                            // see R16
    st_next.pu_req = 1'b0;                            // see R16

    // register writes; registers never reset except by resetn
    if (bus_wr && word_adr == TSR_CTRL_OFS) begin
      st_next.auto_rst = wb_req.dat[CTRL_AUTO_BIT];  // see R06
    end
    if (bus_wr && word_adr == TSR_CHGCTL_OFS) begin
      st_next.term_sel = wb_req.dat[CHG_TERM_LSB +: 2];  // see R11
      st_next.ofs_sel  = wb_req.dat[CHG_OFS_LSB +: 2];   // see R11
    end
    // write one clears the shutdown flag; a set below overrides it
    if (bus_wr && word_adr == TSR_STATUS_OFS &&
        wb_req.dat[STAT_SHUT_BIT]) begin
      st_next.shut_flag = 1'b0;
    end

    // restart governor
    unique case (st_reg.fsm)
      FSM_RUN: begin
        if (hot_shut) begin
          st_next.shut_flag = 1'b1;                   // see R01
          st_next.pd_req    = 1'b1;                   // see R02
          st_next.fsm       = FSM_COOL;
        end
      end
      FSM_COOL: begin
        // hold off until below recovery whatever the triggers do
        if (!hot_recover) begin                       // see R03
          if (st_reg.auto_rst) begin
            st_next.pu_req = 1'b1;                    // see R05
            st_next.fsm    = FSM_RUN;
          end else begin
            st_next.fsm = FSM_WAIT_TRIG;              // see R04
          end
        end
      end
      FSM_WAIT_TRIG: begin
        if (hot_recover) begin
          st_next.fsm = FSM_COOL;                     // see R07
        end else if (trig_rise) begin
          st_next.pu_req = 1'b1;                      // see R04
          st_next.fsm    = FSM_RUN;
        end
      end
      // an unused code waits for cool, the safe side of a glitch
      default: begin
        st_next.fsm = FSM_COOL;
      end
    endcase

    // early warning with hysteresis down to the recovery comparator
    if (hot_early) begin
      st_next.ew_flag = 1'b1;                         // see R08
    end else if (!hot_recover) begin
      st_next.ew_flag = 1'b0;                         // see R09
    end

    // charger current cut follows the regulation comparator
    st_next.limit = hot_reg;                          // see R10

    // voltage levels, restart always relative to termination
    term_calc       = lvl_decode(TERM_BASE_MV, TERM_STEP_MV,
                                 st_reg.term_sel);    // see R13
    st_next.term_mv = term_calc;
    st_next.rst_mv  = LVL_W'(term_calc - lvl_decode(OFS_BASE_MV,
                      OFS_STEP_MV, st_reg.ofs_sel));  // see R12, R14

    // bus answer one cycle after the request, unmapped reads as zero
    st_next.ack  = bus_req;
    st_next.rdat = '0;
    if (bus_req && !wb_req.we) begin
      unique case (word_adr)
        TSR_STATUS_OFS: begin
          st_next.rdat[STAT_SHUT_BIT]  = st_reg.shut_flag;
          st_next.rdat[STAT_EW_BIT]    = st_reg.ew_flag;
          st_next.rdat[STAT_LIMIT_BIT] = st_reg.limit;
          st_next.rdat[STAT_HOT90_BIT] = hot_recover;
          st_next.rdat[STAT_WAIT_BIT]  = st_reg.fsm != FSM_RUN;
        end
        TSR_CHGCTL_OFS: begin
          st_next.rdat[CHG_TERM_LSB +: 2] = st_reg.term_sel;
          st_next.rdat[CHG_OFS_LSB +: 2]  = st_reg.ofs_sel;
        end
        TSR_CTRL_OFS: begin
          st_next.rdat[CTRL_AUTO_BIT] = st_reg.auto_rst;
        end
        default: begin
          st_next.rdat = '0;
        end
      endcase
    end
  end

  // single state register, synchronous active-low reset
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs come straight from the state register
  assign wb_rsp.ack              = st_reg.ack;
  assign wb_rsp.dat              = st_reg.rdat;
  assign power_down_req          = st_reg.pd_req;
  assign power_up_req            = st_reg.pu_req;
  assign charge_current_limit    = st_reg.limit;
  assign term_level_mv           = st_reg.term_mv;
  assign restart_level_mv        = st_reg.rst_mv;
  assign high_temp_shutdown_flag = st_reg.shut_flag;
  assign early_warning_flag      = st_reg.ew_flag;

  // shutdown detection while running sets the flag next cycle
  AST_SHUT_FLAG: assert property (  // see R01
    @(posedge clk_sys) disable iff (!resetn)
    (st_reg.fsm == FSM_RUN && hot_shut) |=> high_temp_shutdown_flag)
    else $error("shutdown flag not set after overheat");

  // the flag only drops on a software write of one to bit 0
  AST_SHUT_STICKY: assert property (  // see R01
    @(posedge clk_sys) disable iff (!resetn)
    (high_temp_shutdown_flag && !(bus_wr && word_adr == TSR_STATUS_OFS &&
      wb_req.dat[STAT_SHUT_BIT])) |=> high_temp_shutdown_flag)
    else $error("shutdown flag dropped without a clear");

  AST_PWR_DOWN: assert property (  // see R02
    @(posedge clk_sys) disable iff (!resetn)
    (st_reg.fsm == FSM_RUN && hot_shut) |=>
      power_down_req && st_reg.fsm == FSM_COOL)
    else $error("no power-down after overheat");

  AST_NO_HOT_RESTART: assert property (@(posedge clk_sys)  // see R03
    disable iff (!resetn)
    $rose(power_up_req) |-> !$past(hot_recover))
    else $error("power-up issued while still hot");

  AST_MANUAL_WAIT: assert property (@(posedge clk_sys)  // see R04
    disable iff (!resetn)
    (st_reg.fsm == FSM_COOL && !st_reg.auto_rst && !hot_recover) |=>
      st_reg.fsm == FSM_WAIT_TRIG && !power_up_req)
    else $error("manual mode restarted without a trigger");

  // a synchronised trigger edge while cool is the only manual restart
  AST_TRIG_RESTART: assert property (  // see R04
    @(posedge clk_sys) disable iff (!resetn)
    (st_reg.fsm == FSM_WAIT_TRIG && !hot_recover && trig_rise) |=>
      power_up_req && st_reg.fsm == FSM_RUN)
    else $error("trigger edge did not restart");

  AST_AUTO_RESTART: assert property (@(posedge clk_sys)  // see R05
    disable iff (!resetn)
    (st_reg.fsm == FSM_COOL && st_reg.auto_rst && !hot_recover) |=>
      power_up_req ##1 !power_up_req)
    else $error("auto restart pulse missing or stuck");

  AST_KEEP_REGS: assert property (  // see R06
    @(posedge clk_sys) disable iff (!resetn)
    (power_up_req && !$past(bus_wr)) |->
      $stable(st_reg.term_sel) && $stable(st_reg.ofs_sel) &&
      $stable(st_reg.auto_rst))
    else $error("restart disturbed programmed registers");

  AST_HOT_BLOCK: assert property (  // see R07
    @(posedge clk_sys) disable iff (!resetn)
    (st_reg.fsm == FSM_WAIT_TRIG && hot_recover) |=>
      !power_up_req && st_reg.fsm == FSM_COOL)
    else $error("power-on allowed while hot");

  AST_EW_SET: assert property (  // see R08
    @(posedge clk_sys) disable iff (!resetn)
    hot_early |=> early_warning_flag)
    else $error("early warning flag not set");

  AST_EW_HOLD: assert property (  // see R09
    @(posedge clk_sys) disable iff (!resetn)
    (early_warning_flag && hot_recover) |=> early_warning_flag)
    else $error("early warning cleared inside hysteresis");

  AST_EW_CLEAR: assert property (  // see R09
    @(posedge clk_sys) disable iff (!resetn)
    (!hot_early && !hot_recover) |=> !early_warning_flag)
    else $error("early warning flag not cleared when cool");

  AST_LIMIT: assert property (  // see R10
    @(posedge clk_sys) disable iff (!resetn)
    hot_reg |=> charge_current_limit)
    else $error("charger current not limited");

  AST_LEVELS: assert property (  // see R11
    @(posedge clk_sys) disable iff (!resetn)
    $stable(st_reg.term_sel) && $stable(st_reg.ofs_sel) |=>
      term_level_mv == LVL_W'(TERM_BASE_MV +
        LVL_W'(TERM_STEP_MV * {11'h0, $past(st_reg.term_sel)})) &&
      LVL_W'(term_level_mv - restart_level_mv) == LVL_W'(OFS_BASE_MV +
        LVL_W'(OFS_STEP_MV * {11'h0, $past(st_reg.ofs_sel)})))
    else $error("charger level decode wrong");

  // pins reach the logic exactly two edges late, once reset has passed
  AST_SYNC_DELAY: assert property (  // see R15
    @(posedge clk_sys) disable iff (!resetn)
    ($past(resetn) && $past(resetn, 2)) |->
      st_reg.cmp_s2 == $past(temp_cmp_in, 2) &&
      st_reg.src_s2[0] == $past(power_key_input, 2) &&
      st_reg.src_s2[1] == $past(charger_supply_input, 2) &&
      st_reg.src_s2[2] == $past(usb_supply_input, 2))
    else $error("input synchroniser depth wrong");

  AST_PD_PULSE: assert property (  // see R16
    @(posedge clk_sys) disable iff (!resetn)
    power_down_req |=> !power_down_req)
    else $error("power-down request longer than a cycle");

  AST_PU_PULSE: assert property (  // see R16
    @(posedge clk_sys) disable iff (!resetn)
    power_up_req |=> !power_up_req)
    else $error("power-up request longer than a cycle");

endmodule
`default_nettype wire

// >>> test/tsr_thermal_ctl_tb.sv
// self-checking bench for the thermal shutdown and restart controller
// assumes a wishbone slave acking one cycle after the taking edge and
// comparator and trigger inputs that pass two sync flops
`default_nettype none
module tsr_thermal_ctl_tb
  import tsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 clk_sys;
  logic                 resetn;
  tsr_wb_req_type       wb_req;
  tsr_wb_rsp_type       wb_rsp;
  logic [CMP_N-1:0]     temp_cmp_in;
  logic [PWR_SRC_N-1:0] trig;
  logic                 power_down_req;
  logic                 power_up_req;
  logic                 charge_current_limit;
  logic [LVL_W-1:0]     term_level_mv;
  logic [LVL_W-1:0]     restart_level_mv;
  logic                 high_temp_shutdown_flag;
  logic                 early_warning_flag;
  logic                 up_d;
  logic                 down_d;
  logic [31:0]          rd;
  logic [31:0]          exp_term;
  int                   mismatches = 0;
  int                   n_tests = 0;
  int                   n_up = 0;
  int                   n_down = 0;

  tsr_thermal_ctl tsr_thermal_ctl_inst (
    .clk_sys(clk_sys), .resetn(resetn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .temp_cmp_in(temp_cmp_in), .power_key_input(trig[0]),
    .charger_supply_input(trig[1]), .usb_supply_input(trig[2]),
    .power_down_req(power_down_req), .power_up_req(power_up_req),
    .charge_current_limit(charge_current_limit),
    .term_level_mv(term_level_mv), .restart_level_mv(restart_level_mv),
    .high_temp_shutdown_flag(high_temp_shutdown_flag),
    .early_warning_flag(early_warning_flag));

  // 25 mhz system clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // pulse counters; a pulse two cycles wide would double-fire the sequencer
  always @(posedge clk_sys) begin
    // non-blocking so a check at the same edge never races the count
    if (power_up_req === 1'b1) n_up <= n_up + 1;
    if (power_down_req === 1'b1) n_down <= n_down + 1;
    if ((power_up_req & up_d) === 1'b1 ||
        (power_down_req & down_d) === 1'b1) begin
      mismatches++;
      $display("wrong value pulse width expected 1 seen 2");
    end
    up_d <= power_up_req;
    down_d <= power_down_req;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // classic single cycle; request held until ack is sampled high
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: s, adr: a, dat: d};
    @(posedge clk_sys);
    while (wb_rsp.ack !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    chk("bus ack", 32'h0000_0001, 32'(wb_rsp.ack));
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    wb_cycle(1'b0, a, 32'h0000_0000, 4'hf);
    chk(what, exp, rd);
  endtask

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (6000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end

  initial begin
    wb_req = '0;
    temp_cmp_in = '0;
    trig = '0;
    resetn = 1'b0;
    tick(2);
    resetn <= 1'b1;
    tick(1);
    // reset values, unmapped place, write without byte lane 0
    chk("term reset", 32'h0000_1068, 32'(term_level_mv));
    chk("restart reset", 32'h0000_1004, 32'(restart_level_mv));
    rd_chk(TSR_STATUS_OFS, 32'h0000_0000, "status reset");
    rd_chk(TSR_CHGCTL_OFS, 32'h0000_0005, "chgctl reset");
    rd_chk(TSR_CTRL_OFS, 32'h0000_0000, "ctrl reset");
    wb_cycle(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
    rd_chk(8'h20, 32'h0000_0000, "unmapped");
    wb_cycle(1'b1, TSR_CTRL_OFS, 32'h0000_0001, 4'he);
    rd_chk(TSR_CTRL_OFS, 32'h0000_0000, "ctrl no lane");
    $display("test reset done");
    // every termination and offset code pair
    for (int t = 0; t < 4; t++) begin
      for (int o = 0; o < 4; o++) begin
        wb_cycle(1'b1, TSR_CHGCTL_OFS, 32'(o * 4 + t), 4'hf);
        tick(3);
        exp_term = 32'(TERM_BASE_MV) + 32'(TERM_STEP_MV) * t;
        chk("term", exp_term, 32'(term_level_mv));
        chk("restart", exp_term - 32'(OFS_BASE_MV) - 32'(OFS_STEP_MV) * o,
            32'(restart_level_mv));
        rd_chk(TSR_CHGCTL_OFS, 32'(o * 4 + t), "chgctl");
      end
    end
    $display("test levels done");
    // early warning hysteresis and current limit
    temp_cmp_in <= 4'b0111;
    tick(4);
    chk("ew set", 32'h0000_0001, 32'(early_warning_flag));
    chk("limit on", 32'h0000_0001, 32'(charge_current_limit));
    rd_chk(TSR_STATUS_OFS, 32'h0000_000e, "status warm");
    temp_cmp_in <= 4'b0001;
    tick(4);
    chk("ew held", 32'h0000_0001, 32'(early_warning_flag));
    chk("limit off", 32'h0000_0000, 32'(charge_current_limit));
    temp_cmp_in <= 4'b0000;
    tick(4);
    chk("ew clear", 32'h0000_0000, 32'(early_warning_flag));
    $display("test warning done");
    // manual restart through each trigger source in turn
    for (int s = 0; s < 3; s++) begin
      temp_cmp_in <= 4'b1111;
      tick(2);
      chk("flag synced", 32'h0000_0000,
          32'(high_temp_shutdown_flag));
      tick(3);
      chk("downs", 32'(s + 1), 32'(n_down));
      rd_chk(TSR_STATUS_OFS, 32'h0000_001f, "status hot");
      temp_cmp_in <= 4'b0001;
      trig[s] <= 1'b1;
      tick(5);
      chk("ups still warm", 32'(s), 32'(n_up));
      trig <= '0;
      temp_cmp_in <= 4'b0000;
      tick(5);
      chk("ups no trigger", 32'(s), 32'(n_up));
      // warm again while waiting: trigger must be refused, back to cool
      temp_cmp_in <= 4'b0001;
      trig[s] <= 1'b1;
      tick(5);
      chk("ups hot wait", 32'(s), 32'(n_up));
      rd_chk(TSR_STATUS_OFS, 32'h0000_0019, "status hot wait");
      trig <= '0;
      temp_cmp_in <= 4'b0000;
      tick(5);
      chk("ups cooled again", 32'(s), 32'(n_up));
      trig[s] <= 1'b1;
      tick(5);
      chk("ups trigger", 32'(s + 1), 32'(n_up));
      trig <= '0;
      wb_cycle(1'b1, TSR_STATUS_OFS, 32'h0000_0001, 4'hf);
      tick(2);
      chk("flag cleared", 32'h0000_0000,
          32'(high_temp_shutdown_flag));
    end
    rd_chk(TSR_STATUS_OFS, 32'h0000_0000, "status running");
    $display("test manual done");
    // automatic restart keeps programmed registers
    wb_cycle(1'b1, TSR_CTRL_OFS, 32'h0000_0001, 4'hf);
    temp_cmp_in <= 4'b1111;
    tick(5);
    chk("downs auto", 32'h0000_0004, 32'(n_down));
    temp_cmp_in <= 4'b0001;
    tick(6);
    chk("ups warm auto", 32'h0000_0003, 32'(n_up));
    temp_cmp_in <= 4'b0000;
    tick(6);
    chk("ups auto", 32'h0000_0004, 32'(n_up));
    rd_chk(TSR_CTRL_OFS, 32'h0000_0001, "ctrl kept");
    rd_chk(TSR_CHGCTL_OFS, 32'h0000_000f, "chgctl kept");
    chk("term kept", 32'h0000_1130, 32'(term_level_mv));
    rd_chk(TSR_STATUS_OFS, 32'h0000_0001, "flag sticky");
    $display("test auto done");
    wrap_up();
  end
endmodule
`default_nettype wire
